// ==== dv/percr_host_model.sv ====
/*
  management host model: page select, single-cycle writes and reads.
  assumes strobes are sampled on the rising edge of clock_in.
*/
`timescale 1ns/1ps
module percr_host_model (
  // clock
  input wire logic clock_in,
  // management port toward the bank
  output logic [4:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [15:0] rdata_in
);
  // ********************************
  // bus cycles
  // ********************************
  initial begin
    {addr_out, wdata_out, wr_out, rd_out} = 23'h0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rdata_in;
  endtask
  // two reads with no gap between the strobes
  task automatic rd_pair(input logic [4:0] a, output logic [15:0] d0, output logic [15:0] d1);
    @(posedge clock_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    #1 d0 = rdata_in;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 d1 = rdata_in;
  endtask
  task automatic page_set(input logic on);
    wr_reg(percr_pkg::ADDR_PAGE, on ? percr_pkg::PAGE_EXTENDED : percr_pkg::PAGE_MAIN);
  endtask
endmodule // percr_host_model

// ==== dv/percr_regs_properties.sv ====
/*
  checker for the extended control register bank, bound to percr_regs.
  assumes the management port and outputs of percr_regs on one clock.
*/
`timescale 1ns/1ps
module percr_regs_chk (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // management port
  input wire logic [4:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  // events and controls
  input wire logic good_crc_packet_in,
  input wire logic [3:0] indicator_ext_mode_out,
  input wire logic media_loop_en_out,
  input wire logic mac_loop_en_out,
  input wire logic far_loop_iso_block_out,
  input wire logic fast_fail_en_out,
  input wire logic shared_io_pin_nine_gpio_out,
  input wire logic xover_auto_out,
  input wire logic xover_crossed_out,
  input wire logic [1:0] sleep_sel_out,
  input wire logic [2:0] dshift_attempts_out
);
  // ********************************
  // page tracking and properties
  // ********************************
  logic page_on_r;
  logic crc_rd;
  logic ext_wr;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  assign crc_rd = rd_in && (addr_in == percr_pkg::ADDR_CRC_GOOD);
  assign ext_wr = wr_in && page_on_r;
  // own copy of the page register so reads can be judged without the body
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      page_on_r <= 1'b0;
    end else if (wr_in && addr_in == percr_pkg::ADDR_PAGE) begin
      page_on_r <= (wdata_in == percr_pkg::PAGE_EXTENDED);
    end
  end
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside read answer");
  page_off_a: assert property (crc_rd && !page_on_r |=> rdata_out == 16'h0000)
    else $error("counter visible with page off");
  seen_flag_a: assert property (good_crc_packet_in && !crc_rd ##1 crc_rd && page_on_r
    |=> rdata_out[15]) else $error("packet flag missing");
  clear_read_a: assert property (crc_rd && page_on_r && !good_crc_packet_in ##1 crc_rd
    |=> rdata_out == 16'h0000) else $error("counter not cleared by read");
  ind_write_a: assert property (ext_wr && addr_in == percr_pkg::ADDR_LOOP_DET
    |-> ##2 indicator_ext_mode_out == $past(wdata_in[15:12], 2)) else $error("indicator");
  far_block_a: assert property (far_loop_iso_block_out ==
    (media_loop_en_out || mac_loop_en_out)) else $error("far loop block wrong");
  pin_nine_a: assert property (shared_io_pin_nine_gpio_out != fast_fail_en_out)
    else $error("pin nine mode wrong");
  xover_excl_a: assert property (xover_crossed_out |-> !xover_auto_out)
    else $error("crossover both auto and forced");
  sleep_write_a: assert property (ext_wr && addr_in == percr_pkg::ADDR_PWR_SPEED
    |-> ##2 sleep_sel_out == $past(wdata_in[14:13], 2)) else $error("sleep select");
  attempts_range_a: assert property (dshift_attempts_out inside {[3'h2:3'h5]})
    else $error("attempt count out of range");
endmodule // percr_regs_chk

bind percr_regs percr_regs_chk u_chk (.clock_in, .reset_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .good_crc_packet_in, .indicator_ext_mode_out, .media_loop_en_out,
  .mac_loop_en_out, .far_loop_iso_block_out, .fast_fail_en_out, .shared_io_pin_nine_gpio_out,
  .xover_auto_out, .xover_crossed_out, .sleep_sel_out, .dshift_attempts_out);

// ==== dv/tb_top.sv ====
/*
  self-checking bench for percr_regs with a host model and random stimulus.
  assumes the hand-over timing: read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, rv, d;
  logic wr, rd, pk, sb, sl, sc, sd, sig, dst, blk, mle, xle, fib, ffe, gpo, xau, xcr;
  logic sdo, nce, ckf, npr, dse;
  logic [1:0] med, mlm, xlm, slp, wak;
  logic [2:0] att;
  logic [3:0] ind;
  int error_cnt, tests_run, cyc, i, n;
  always #10 clock_in = ~clock_in;
  percr_host_model u_host (.clock_in, .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));
  percr_regs u_dut (.clock_in, .reset_in, .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .strap_blink_in(sb), .strap_signal_detect_input_low_in(sl),
    .strap_clk_fast_in(sc), .strap_dshift_en_in(sd), .good_crc_packet_in(pk),
    .media_status_in(med), .dshift_status_in(dst), .signal_detect_input(sig),
    .indicator_ext_mode_out(ind), .indicator_blink_out(blk), .media_loop_en_out(mle),
    .media_loop_mode_out(mlm), .mac_loop_en_out(xle), .mac_loop_mode_out(xlm),
    .far_loop_iso_block_out(fib), .fast_fail_en_out(ffe), .shared_io_pin_nine_gpio_out(gpo),
    .xover_auto_out(xau), .xover_crossed_out(xcr), .signal_detect_out(sdo),
    .no_carrier_ext_out(nce), .sleep_sel_out(slp), .wake_sel_out(wak),
    .clock_output_pin_fast_out(ckf), .no_preamble_out(npr), .dshift_en_out(dse),
    .dshift_attempts_out(att));
  // ********************************
  // checking and closing
  // ********************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [15:0] f14(logic [15:0] w, logic [1:0] m, logic s);
    return (w & 16'hf93c) | {8'h00, (m == 2'h3) ? 2'h0 : m, 4'h0, s, 1'b0};
  endfunction
  // bound well above the longest run, the counter wrap
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ********************************
  // scenarios
  // ********************************
  initial begin
    rv = $urandom(32'ha77d983b);
    {sb, sl, sc, sd} = 4'($urandom);
    {sig, pk, med, dst} = 5'h00;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    u_host.rd_reg(percr_pkg::ADDR_CRC_GOOD, rv);
    chk(rv, 16'h0000);
    u_host.wr_reg(percr_pkg::ADDR_LOOP_DET, 16'hffff);
    u_host.page_set(1'b1);
    u_host.rd_reg(percr_pkg::ADDR_PAGE, rv);
    chk(rv, 16'h0001);
    u_host.rd_reg(percr_pkg::ADDR_LOOP_DET, rv);
    chk(rv, {4'h0, sb, 10'h000, sl});
    u_host.rd_reg(percr_pkg::ADDR_PWR_SPEED, rv);
    chk(rv, 16'h3804 | {7'h00, sc, 3'h0, sd, 4'h0});
    chk({15'h0000, blk}, {15'h0000, sb});
    for (i = 0; i < 24; i++) begin
      d = 16'($urandom);
      if (i < 4) d[3:2] = i[1:0];
      @(posedge clock_in);
      sig <= 1'($urandom);
      u_host.wr_reg(percr_pkg::ADDR_LOOP_DET, d);
      u_host.rd_reg(percr_pkg::ADDR_LOOP_DET, rv);
      chk(rv, d & percr_pkg::LD_WR_MASK);
      chk({ind, blk, mle, mlm, xle, xlm, ffe, xcr, xau, gpo, sdo},
        {d[15:4], d[3:2] == 2'h3, !d[3], !d[4], sig ^ d[0]});
      chk({15'h0000, fib}, {15'h0000, d[10] | d[7]});
      d = 16'($urandom);
      if (i < 4) d[3:2] = i[1:0];
      @(posedge clock_in);
      {med, dst} <= 3'($urandom);
      u_host.wr_reg(percr_pkg::ADDR_PWR_SPEED, d);
      u_host.rd_reg(percr_pkg::ADDR_PWR_SPEED, rv);
      chk(rv, f14(d, med, dst));
      chk({nce, slp, wak, ckf, npr, dse, att, 5'h00},
        {d[15:11], d[8], d[5], d[4], 3'(d[3:2]) + 3'h2, 5'h00});
    end
    u_host.wr_reg(5'h15, 16'hffff);
    u_host.rd_reg(5'h15, rv);
    chk(rv, 16'h0000);
    n = 1 + ($urandom % 20);
    repeat (n) begin
      @(posedge clock_in);
      pk <= 1'b1;
      @(posedge clock_in);
      pk <= 1'b0;
    end
    u_host.rd_reg(percr_pkg::ADDR_CRC_GOOD, rv);
    chk(rv, {2'b10, 14'(n)});
    u_host.rd_reg(percr_pkg::ADDR_CRC_GOOD, rv);
    chk(rv, 16'h0000);
    fork
      u_host.rd_reg(percr_pkg::ADDR_CRC_GOOD, rv);
      begin
        @(posedge clock_in);
        pk <= 1'b1;
        @(posedge clock_in);
        pk <= 1'b0;
      end
    join
    chk(rv, 16'h0000);
    u_host.rd_reg(percr_pkg::ADDR_CRC_GOOD, rv);
    chk(rv, 16'h8001);
    // packet just ahead of two back-to-back reads
    @(posedge clock_in);
    pk <= 1'b1;
    fork
      u_host.rd_pair(percr_pkg::ADDR_CRC_GOOD, rv, d);
      @(posedge clock_in) pk <= 1'b0;
    join
    chk(rv, 16'h8001);
    chk(d, 16'h0000);
    @(posedge clock_in);
    pk <= 1'b1;
    repeat (16385) @(posedge clock_in);
    pk <= 1'b0;
    u_host.rd_reg(percr_pkg::ADDR_CRC_GOOD, rv);
    chk(rv, 16'h8001);
    close_out();
  end
endmodule // tb_top

// ==== verilog/percr_pkg.sv ====
/*
  constants for the extended control register bank: page select, offsets,
  field positions, reset values and decode codes.
  assumes nothing beyond a management register port of 5-bit address, 16-bit data.
*/
package percr_pkg;
  // ****************************************************************
  // addressing
  // ****************************************************************
  localparam logic [4:0] ADDR_PAGE = 5'h1f;
  localparam logic [15:0] PAGE_EXTENDED = 16'h0001;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [4:0] ADDR_EXT_LO = 5'h10;
  localparam logic [4:0] ADDR_EXT_HI = 5'h1e;
  localparam logic [4:0] ADDR_CRC_GOOD = 5'h12;
  localparam logic [4:0] ADDR_LOOP_DET = 5'h13;
  localparam logic [4:0] ADDR_PWR_SPEED = 5'h14;

  // ****************************************************************
  // good-crc counter fields
  // ****************************************************************
  localparam int CRC_SEEN_BIT = 15;
  localparam int CRC_CNT_W = 14;

  // ****************************************************************
  // loopback / detect fields
  // ****************************************************************
  localparam int LD_IND_HI = 15;
  localparam int LD_IND_LO = 12;
  localparam int LD_BLINK = 11;
  localparam int LD_MEDIA_LB_EN = 10;
  localparam int LD_MEDIA_MODE_HI = 9;
  localparam int LD_MEDIA_MODE_LO = 8;
  localparam int LD_MAC_LB_EN = 7;
  localparam int LD_MAC_MODE_HI = 6;
  localparam int LD_MAC_MODE_LO = 5;
  localparam int LD_FAST_FAIL = 4;
  localparam int LD_XOVER_HI = 3;
  localparam int LD_XOVER_LO = 2;
  localparam int LD_SIGNAL_DETECT_INPUT_POL = 0;
  localparam logic [15:0] LD_WR_MASK = 16'hfffd;

  // ****************************************************************
  // power-save / speed fields
  // ****************************************************************
  localparam int PS_NO_CEXT = 15;
  localparam int PS_SLEEP_HI = 14;
  localparam int PS_SLEEP_LO = 13;
  localparam int PS_WAKE_HI = 12;
  localparam int PS_WAKE_LO = 11;
  localparam int PS_CLK_SEL = 8;
  localparam int PS_MEDIA_HI = 7;
  localparam int PS_MEDIA_LO = 6;
  localparam int PS_NO_PREAMBLE = 5;
  localparam int PS_DSHIFT_EN = 4;
  localparam int PS_DSHIFT_HI = 3;
  localparam int PS_DSHIFT_LO = 2;
  localparam int PS_DSHIFT_STAT = 1;
  // media, status and reserved bits 10, 9, 0 never take write data
  localparam logic [15:0] PS_WR_MASK = 16'hf93c;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [1:0] SLEEP_RST = 2'h1;
  localparam logic [1:0] WAKE_RST = 2'h3;
  localparam logic [1:0] DSHIFT_RST = 2'h1;
  localparam logic [1:0] LB_MODE_RST = 2'h0;
  localparam logic [1:0] XOVER_AUTO = 2'h0;
  localparam logic [1:0] XOVER_RSVD = 2'h1;
  localparam logic [1:0] XOVER_STRAIGHT = 2'h2;
  localparam logic [1:0] XOVER_CROSSED = 2'h3;
  localparam logic [1:0] MEDIA_RSVD = 2'h3;
  localparam logic [2:0] DSHIFT_BASE = 3'h2;
endpackage

// ==== verilog/percr_regs.sv ====
/*
  extended-page control register bank: good-crc counter, serial loopback and
  detect control, power-save and speed control.
  assumes a management port on clock_in, straps stable at reset release,
  and event/status inputs already on clock_in.
*/
`timescale 1ns/1ps
module percr_regs #(
  parameter bit IS_FIRST_PORT = 1'b1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // management register port
  input wire logic [4:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // straps, sampled after reset release
  input wire logic strap_blink_in,
  input wire logic strap_signal_detect_input_low_in,
  input wire logic strap_clk_fast_in,
  input wire logic strap_dshift_en_in,
  // device status and events
  input wire logic good_crc_packet_in,
  input wire logic [1:0] media_status_in,
  input wire logic dshift_status_in,
  input wire logic signal_detect_input,
  // control outputs
  output logic [3:0] indicator_ext_mode_out,
  output logic indicator_blink_out,
  output logic media_loop_en_out,
  output logic [1:0] media_loop_mode_out,
  output logic mac_loop_en_out,
  output logic [1:0] mac_loop_mode_out,
  output logic far_loop_iso_block_out,
  output logic fast_fail_en_out,
  output logic shared_io_pin_nine_gpio_out,
  output logic xover_auto_out,
  output logic xover_crossed_out,
  output logic signal_detect_out,
  output logic no_carrier_ext_out,
  output logic [1:0] sleep_sel_out,
  output logic [1:0] wake_sel_out,
  output logic clock_output_pin_fast_out,
  output logic no_preamble_out,
  output logic dshift_en_out,
  output logic [2:0] dshift_attempts_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] page;
    logic strap_done;
    logic pkt_seen;
    logic [13:0] crc_cnt;
    logic [15:0] loop_det;
    logic [15:0] pwr;
    logic [1:0] media;
    logic dshift_stat;
    logic [1:0] sd_sync;
    logic [15:0] rdata;
    logic [3:0] ind;
    logic blink;
    logic m_en;
    logic [1:0] m_mode;
    logic c_en;
    logic [1:0] c_mode;
    logic block;
    logic ff_en;
    logic gpio;
    logic x_auto;
    logic x_cross;
    logic sd;
    logic no_cext;
    logic [1:0] sleep;
    logic [1:0] wake;
    logic clk_fast;
    logic no_pre;
    logic ds_en;
    logic [2:0] ds_att;
  } percr_state_s;

  percr_state_s st_r;
  percr_state_s st_nxt;

  // extended window decode used by both read and write paths
  function automatic logic ext_hit(input logic [15:0] page, input logic [4:0] a,
                                   input logic [4:0] reg_a);
    ext_hit = (page == percr_pkg::PAGE_EXTENDED) && (a == reg_a);
  endfunction

  logic [15:0] crc_view;
  logic [15:0] pwr_view;
  logic rd_crc;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    crc_view = '0;
    crc_view[percr_pkg::CRC_SEEN_BIT] = st_r.pkt_seen;
    crc_view[percr_pkg::CRC_CNT_W-1:0] = st_r.crc_cnt;
    pwr_view = st_r.pwr;
    pwr_view[percr_pkg::PS_MEDIA_HI:percr_pkg::PS_MEDIA_LO] = st_r.media;
    pwr_view[percr_pkg::PS_DSHIFT_STAT] = st_r.dshift_stat;
    rd_crc = rd_in && ext_hit(st_r.page, addr_in, percr_pkg::ADDR_CRC_GOOD);

    // status capture; reserved media code is not reported
    st_nxt.media = (media_status_in == percr_pkg::MEDIA_RSVD) ? 2'h0 : media_status_in;
    st_nxt.dshift_stat = dshift_status_in;
    st_nxt.sd_sync = {st_r.sd_sync[0], signal_detect_input};

    // straps land once, the first cycle after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.loop_det[percr_pkg::LD_BLINK] = strap_blink_in;
      st_nxt.loop_det[percr_pkg::LD_SIGNAL_DETECT_INPUT_POL] = strap_signal_detect_input_low_in;
      st_nxt.pwr[percr_pkg::PS_CLK_SEL] = IS_FIRST_PORT & strap_clk_fast_in;
      st_nxt.pwr[percr_pkg::PS_DSHIFT_EN] = strap_dshift_en_in;
    end

    // read clears the counter; an event in that cycle survives as one count
    if (rd_crc) begin
      st_nxt.pkt_seen = good_crc_packet_in;
      st_nxt.crc_cnt = good_crc_packet_in ? 14'h0001 : 14'h0000;
    end else if (good_crc_packet_in) begin
      st_nxt.pkt_seen = 1'b1;
      st_nxt.crc_cnt = st_r.crc_cnt + 14'h0001;
    end

    // writes
    if (wr_in) begin
      if (addr_in == percr_pkg::ADDR_PAGE) begin
        st_nxt.page = wdata_in;
      end else if (ext_hit(st_r.page, addr_in, percr_pkg::ADDR_LOOP_DET)) begin
        st_nxt.loop_det = wdata_in & percr_pkg::LD_WR_MASK;
      end else if (ext_hit(st_r.page, addr_in, percr_pkg::ADDR_PWR_SPEED)) begin
        st_nxt.pwr = wdata_in & percr_pkg::PS_WR_MASK;
        // clock select only exists in the first port copy
        if (!IS_FIRST_PORT) begin
          st_nxt.pwr[percr_pkg::PS_CLK_SEL] = 1'b0;
        end
      end
    end

    // reads: data lands one cycle later; unmapped reads give zero
    st_nxt.rdata = '0;
    if (rd_in) begin
      if (addr_in == percr_pkg::ADDR_PAGE) begin
        st_nxt.rdata = st_r.page;
      end else if (rd_crc) begin
        st_nxt.rdata = crc_view;
      end else if (ext_hit(st_r.page, addr_in, percr_pkg::ADDR_LOOP_DET)) begin
        st_nxt.rdata = st_r.loop_det;
      end else if (ext_hit(st_r.page, addr_in, percr_pkg::ADDR_PWR_SPEED)) begin
        st_nxt.rdata = pwr_view;
      end
    end

    // decoded controls, registered straight to outputs
    st_nxt.ind = st_r.loop_det[percr_pkg::LD_IND_HI:percr_pkg::LD_IND_LO];
    st_nxt.blink = st_r.loop_det[percr_pkg::LD_BLINK];
    st_nxt.m_en = st_r.loop_det[percr_pkg::LD_MEDIA_LB_EN];
    st_nxt.m_mode = st_r.loop_det[percr_pkg::LD_MEDIA_MODE_HI:percr_pkg::LD_MEDIA_MODE_LO];
    st_nxt.c_en = st_r.loop_det[percr_pkg::LD_MAC_LB_EN];
    st_nxt.c_mode = st_r.loop_det[percr_pkg::LD_MAC_MODE_HI:percr_pkg::LD_MAC_MODE_LO];
    // either loopback overrides far-end loopback and isolate
    st_nxt.block = st_r.loop_det[percr_pkg::LD_MEDIA_LB_EN] |
                   st_r.loop_det[percr_pkg::LD_MAC_LB_EN];
    st_nxt.ff_en = st_r.loop_det[percr_pkg::LD_FAST_FAIL];
    st_nxt.gpio = ~st_r.loop_det[percr_pkg::LD_FAST_FAIL];
    // reserved crossover code falls back to automatic
    case (st_r.loop_det[percr_pkg::LD_XOVER_HI:percr_pkg::LD_XOVER_LO])
      percr_pkg::XOVER_STRAIGHT: begin
        st_nxt.x_auto = 1'b0;
        st_nxt.x_cross = 1'b0;
      end
      percr_pkg::XOVER_CROSSED: begin
        st_nxt.x_auto = 1'b0;
        st_nxt.x_cross = 1'b1;
      end
      default: begin
        st_nxt.x_auto = 1'b1;
        st_nxt.x_cross = 1'b0;
      end
    endcase
    // normalised to active high
    st_nxt.sd = st_r.sd_sync[1] ^ st_r.loop_det[percr_pkg::LD_SIGNAL_DETECT_INPUT_POL];
    st_nxt.no_cext = st_r.pwr[percr_pkg::PS_NO_CEXT];
    st_nxt.sleep = st_r.pwr[percr_pkg::PS_SLEEP_HI:percr_pkg::PS_SLEEP_LO];
    st_nxt.wake = st_r.pwr[percr_pkg::PS_WAKE_HI:percr_pkg::PS_WAKE_LO];
    st_nxt.clk_fast = st_r.pwr[percr_pkg::PS_CLK_SEL];
    st_nxt.no_pre = st_r.pwr[percr_pkg::PS_NO_PREAMBLE];
    st_nxt.ds_en = st_r.pwr[percr_pkg::PS_DSHIFT_EN];
    st_nxt.ds_att = {1'b0, st_r.pwr[percr_pkg::PS_DSHIFT_HI:percr_pkg::PS_DSHIFT_LO]} +
                    percr_pkg::DSHIFT_BASE;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= '0;
      st_r.page <= percr_pkg::PAGE_MAIN;
      st_r.pwr[percr_pkg::PS_SLEEP_HI:percr_pkg::PS_SLEEP_LO] <= percr_pkg::SLEEP_RST;
      st_r.pwr[percr_pkg::PS_WAKE_HI:percr_pkg::PS_WAKE_LO] <= percr_pkg::WAKE_RST;
      st_r.pwr[percr_pkg::PS_DSHIFT_HI:percr_pkg::PS_DSHIFT_LO] <= percr_pkg::DSHIFT_RST;
      st_r.sleep <= percr_pkg::SLEEP_RST;
      st_r.wake <= percr_pkg::WAKE_RST;
      st_r.ds_att <= {1'b0, percr_pkg::DSHIFT_RST} + percr_pkg::DSHIFT_BASE;
      st_r.x_auto <= 1'b1;
      st_r.gpio <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_out = st_r.rdata;
  assign indicator_ext_mode_out = st_r.ind;
  assign indicator_blink_out = st_r.blink;
  assign media_loop_en_out = st_r.m_en;
  assign media_loop_mode_out = st_r.m_mode;
  assign mac_loop_en_out = st_r.c_en;
  assign mac_loop_mode_out = st_r.c_mode;
  assign far_loop_iso_block_out = st_r.block;
  assign fast_fail_en_out = st_r.ff_en;
  assign shared_io_pin_nine_gpio_out = st_r.gpio;
  assign xover_auto_out = st_r.x_auto;
  assign xover_crossed_out = st_r.x_cross;
  assign signal_detect_out = st_r.sd;
  assign no_carrier_ext_out = st_r.no_cext;
  assign sleep_sel_out = st_r.sleep;
  assign wake_sel_out = st_r.wake;
  assign clock_output_pin_fast_out = st_r.clk_fast;
  assign no_preamble_out = st_r.no_pre;
  assign dshift_en_out = st_r.ds_en;
  assign dshift_attempts_out = st_r.ds_att;

endmodule // percr_regs
